// ### bench/mfp_rx_place_sva.sv
/* Port checker for mfp_rx_place, bound below.
   Assumes one clock and registered one-cycle pulses. */
`timescale 1ns/1ps
module mfp_rx_place_sva (
  input wire logic                i_core_clk,
  input wire logic                i_rst_n,
  input wire mfp_pkg::mfp_byte_s  i_byte,
  input wire logic                o_in_ready,
  input wire mfp_pkg::mfp_wr_s    o_wr,
  input wire mfp_pkg::mfp_errev_s o_err,
  input wire mfp_pkg::mfp_dlv_s   o_deliver
);
  // ====================
  // Rules at the ports
  // ====================
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic sop_wait; // Start offered, not yet accepted
  logic crc_bad;  // Failed check reported
  assign sop_wait = i_byte.valid & i_byte.sop & ~o_in_ready;
  assign crc_bad  = o_err.valid & (o_err.code == mfp_pkg::ERR_CRC);
  a_reset_quiet: assert property (disable iff (1'b0) !i_rst_n |->
    !(o_in_ready | o_wr.valid | o_err.valid | o_deliver.valid)) else $error("busy in reset");
  a_ready_answer: assert property ($rose(sop_wait) |-> ##[2:300] o_in_ready)
    else $error("segment not taken");
  a_eop_drop: assert property (i_byte.valid & i_byte.eop & o_in_ready |=> !o_in_ready)
    else $error("ready past end");
  a_copy_stall: assert property (o_wr.valid |-> !$past(o_in_ready))
    else $error("write while taking");
  a_crc_nowrite: assert property (crc_bad |-> !o_wr.valid [*4])
    else $error("write after bad check");
  a_err_pulse: assert property (o_err.valid |->
    o_err.code != mfp_pkg::ERR_NONE ##1 !o_err.valid) else $error("bad error pulse");
  a_dlv_pulse: assert property (o_deliver.valid |=> !o_deliver.valid)
    else $error("long delivery");
  a_dlv_last: assert property (o_deliver.valid |-> !o_in_ready ##1 !o_wr.valid)
    else $error("delivery mid placement");
  c_write: cover property (o_wr.valid);
  c_dlv: cover property (o_deliver.valid);
  c_crc: cover property (crc_bad);
endmodule : mfp_rx_place_sva
bind mfp_rx_place mfp_rx_place_sva u_sva (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_byte(i_byte), .o_in_ready(o_in_ready), .o_wr(o_wr), .o_err(o_err),
  .o_deliver(o_deliver));

// ### bench/mfp_seg_src.sv
/* Remote sender model: offers a segment payload one byte at a time.
   Assumes the engine's ready is registered on the rising edge. */
`timescale 1ns/1ps
module mfp_seg_src (
  input  wire logic          i_core_clk,
  input  wire logic          i_ready,
  output mfp_pkg::mfp_byte_s o_byte
);
  // ====================
  // Byte driver
  // ====================
  initial o_byte = '{1'b0, 1'b0, 1'b0, 8'hA5};
  // Each byte stands until an edge that sees ready high
  task automatic send(input logic [7:0] seg[$]);
    logic rdy;
    for (int i = 0; i < seg.size(); i++) begin
      @(negedge i_core_clk);
      o_byte = '{1'b1, i == 0, i == seg.size() - 1, seg[i]};
      rdy = i_ready;
      @(posedge i_core_clk);
      while (!rdy) begin
        @(negedge i_core_clk);
        rdy = i_ready;
        @(posedge i_core_clk);
      end
    end
    @(negedge i_core_clk);
    // Released data shows the inverse, never a stale copy
    o_byte = '{1'b0, 1'b0, 1'b0, ~o_byte.data};
  endtask : send
endmodule : mfp_seg_src

// ### bench/test_mfp_rx_place.sv
/* Bench for mfp_rx_place; mfp_seg_src plays the remote sender.
   Assumes the bound checker. */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module test_mfp_rx_place;
  logic                clk;
  logic                rst_n;
  logic                rdy;
  mfp_pkg::mfp_tuple_s tuple;
  mfp_pkg::mfp_meta_s  meta;
  mfp_pkg::mfp_cfg_s   cfg;
  mfp_pkg::mfp_byte_s  bi;
  mfp_pkg::mfp_wr_s    wr;
  mfp_pkg::mfp_errev_s err;
  mfp_pkg::mfp_dlv_s   dlv;
  int                  n_errors = 0;
  int                  total_checks = 0;
  int                  n_dlv = 0; // Delivery pulses
  logic [7:0]          dlv_conn;  // Last delivered connection
  int                  cyc = 0;   // Hang guard
  logic [7:0]          seg[$];    // Segment being built
  logic [39:0]         wrq[$];    // Writes seen
  logic [39:0]         expq[$];   // Writes expected
  mfp_pkg::mfp_err_e   errq[$];   // Errors seen
  // ====================
  // Clock, engine, sender
  // ====================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Small buffers keep every case short
  mfp_rx_place #(.NUM_CONN(2), .FPDU_MAX(32), .HOLD_DEPTH(32)) uut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_byte(bi), .i_tuple(tuple), .i_meta(meta),
    .i_cfg(cfg), .o_in_ready(rdy), .o_wr(wr), .o_err(err), .o_deliver(dlv));
  mfp_seg_src src (.i_core_clk(clk), .i_ready(rdy), .o_byte(bi));
  // Pulses read mid-cycle, once settled
  always @(negedge clk) begin
    if (wr.valid === 1'b1) wrq.push_back({wr.addr, wr.data});
    if (err.valid === 1'b1) errq.push_back(err.code);
    if (dlv.valid === 1'b1) begin
      n_dlv++;
      dlv_conn = dlv.conn;
    end
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ====================
  // Helpers
  // ====================
  function automatic mfp_pkg::mfp_tuple_s tup(input logic [7:0] k);
    return {32'hC0A80001, 32'hC0A80002, 8'h10, k, 16'h0FA0, 8'h06};
  endfunction : tup
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h000000, d};
    repeat (8) c = c[0] ? ((c >> 1) ^ mfp_pkg::CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc8
  // Append one FPDU; bad flips a check bit
  task automatic add_fpdu(input logic [31:0] a, input int n, input logic [7:0] d0,
                          input logic bad);
    logic [7:0]  f[$];
    logic [31:0] c;
    logic [15:0] l;
    l = 16'(n + 4);
    c = mfp_pkg::CRC_INIT;
    f = {l[15:8], l[7:0], a[31:24], a[23:16], a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      f.push_back(d0 + 8'(i));
      if (!bad) expq.push_back({a + 32'(i), d0 + 8'(i)});
    end
    while (f.size() % 4 != 0) f.push_back(8'h00);
    foreach (f[i]) c = crc8(c, f[i]);
    c = ~c ^ {31'h00000000, bad};
    seg = {seg, f, c[31:24], c[23:16], c[15:8], c[7:0]};
  endtask : add_fpdu
  // Offer the segment, let it settle, compare all seen
  task automatic run(input logic [7:0] k, input mfp_pkg::mfp_meta_s m,
                     input mfp_pkg::mfp_err_e e, input int nd);
    @(negedge clk);
    tuple = tup(k);
    meta = m;
    src.send(seg);
    seg.delete();
    repeat (60) @(negedge clk);
    `CHK(wrq.size(), expq.size())
    foreach (expq[i]) if (i < wrq.size()) `CHK(wrq[i], expq[i])
    `CHK(errq.size(), int'(e != mfp_pkg::ERR_NONE))
    if (errq.size() > 0) `CHK(errq[0], e)
    `CHK(n_dlv, nd)
    if (nd > 0) `CHK(dlv_conn, k)
    wrq.delete();
    expq.delete();
    errq.delete();
    n_dlv = 0;
  endtask : run
  // ====================
  // Scenarios
  // ====================
  task automatic t_aligned();
    add_fpdu(32'h00001000, 1, 8'h5A, 1'b0);
    run(8'h00, 4'hA, mfp_pkg::ERR_NONE, 1);
    $display("test aligned done");
  endtask : t_aligned
  task automatic t_packed();
    add_fpdu(32'h00002000, 2, 8'h20, 1'b0);
    add_fpdu(32'h00003000, 8, 8'hC0, 1'b0);
    run(8'h00, 4'hA, mfp_pkg::ERR_NONE, 1);
    $display("test packed done");
  endtask : t_packed
  task automatic t_badcrc();
    add_fpdu(32'h00003800, 3, 8'h44, 1'b1);
    run(8'h00, 4'hA, mfp_pkg::ERR_CRC, 0);
    $display("test bad check done");
  endtask : t_badcrc
  // Split FPDU: in order, or tail first and held
  task automatic t_two(input logic [7:0] k, input logic ooo);
    logic [7:0]  head[$];
    logic [7:0]  tail[$];
    logic [39:0] keep[$];
    add_fpdu(32'h00004000, 8, 8'h30, 1'b0);
    head = seg[0:6];
    tail = seg[7:$];
    keep = expq;
    expq.delete();
    seg = head;
    if (ooo) seg = tail;
    run(k, ooo ? 4'h8 : 4'hA, mfp_pkg::ERR_NONE, 0);
    seg = tail;
    if (ooo) seg = head;
    expq = keep;
    run(k, 4'hA, mfp_pkg::ERR_NONE, 1);
    $display("test split %0d done", ooo);
  endtask : t_two
  // Out-of-order aligned: placed at once, not delivered at segment end
  task automatic t_marker();
    add_fpdu(32'h00005000, 2, 8'h77, 1'b0);
    run(8'h01, 4'h9, mfp_pkg::ERR_NONE, 0);
    add_fpdu(32'h00005800, 2, 8'h66, 1'b0);
    seg = seg[0:8];
    expq.delete();
    run(8'h01, 4'h9, mfp_pkg::ERR_ALIGN, 0);
    $display("test marker done");
  endtask : t_marker
  // Refused segments: nothing placed
  task automatic t_refuse();
    mfp_pkg::mfp_err_e codes[4] = '{mfp_pkg::ERR_L34, mfp_pkg::ERR_FRAG,
                                    mfp_pkg::ERR_NOCONN, mfp_pkg::ERR_LEN};
    logic [3:0]        metas[4] = '{4'h2, 4'hE, 4'hA, 4'hA};
    for (int i = 0; i < 4; i++) begin
      add_fpdu(32'h00006000, (i == 3) ? 0 : 2, 8'h11, 1'b0);
      expq.delete();
      run((i == 2) ? 8'h07 : 8'h00, metas[i], codes[i], 0);
    end
    $display("test refuse done");
  endtask : t_refuse
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    rst_n = 1'b0;
    tuple = '0;
    meta = '0;
    cfg = '0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      cfg = '{1'b1, 8'(k), tup(8'(k))};
      @(negedge clk);
    end
    cfg = '0;
    t_aligned();
    t_packed();
    t_badcrc();
    t_two(8'h01, 1'b0);
    t_two(8'h00, 1'b1);
    t_marker();
    t_refuse();
    print_verdict();
  end
endmodule : test_mfp_rx_place

// ### rtl/mfp_pkg.sv
/*
  Shared constants, carrier structs, state and error enumerations and the
  CRC32C byte step for the FPDU receive placement engine.
  Assumes a single clock domain; all carriers are produced and consumed
  by logic on that clock.
*/
package mfp_pkg;

  // ==========================================================================
  // Framing constants
  // ==========================================================================
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF; // CRC32C seed
  localparam logic [31:0] CRC_POLY    = 32'h82F63B78; // Reflected CRC32C poly
  localparam logic [15:0] HDR_BYTES   = 16'h0002;     // Length field size
  localparam logic [15:0] CRC_BYTES   = 16'h0004;     // Trailing check size
  localparam logic [16:0] PAD_MASK    = 17'h00003;    // Pad to four octets
  localparam logic [15:0] PLACE_HDR   = 16'h0004;     // Host address prefix
  localparam logic [15:0] PLACE_START = 16'h0006;     // First placed offset
  localparam logic [1:0]  PH_HDR      = 2'h0;         // Reading length
  localparam logic [1:0]  PH_BODY     = 2'h1;         // Header, data, pad
  localparam logic [1:0]  PH_CRC      = 2'h2;         // Reading check value
  localparam int          FPDU_MAX_DEF = 140;         // Least split buffer
  localparam int          HOLD_DEF     = 140;         // Out-of-order hold

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE, ST_CLASS, ST_RUN, ST_CHECK, ST_COPY, ST_HOLD, ST_DRAIN
  } mfp_st_e;

  typedef enum logic [2:0] {
    ERR_NONE, ERR_L34, ERR_FRAG, ERR_NOCONN, ERR_HOLD, ERR_LEN, ERR_ALIGN, ERR_CRC
  } mfp_err_e;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [31:0] ip_src;
    logic [31:0] ip_dst;
    logic [15:0] port_src;
    logic [15:0] port_dst;
    logic [7:0]  proto;
  } mfp_tuple_s;

  typedef struct packed {
    logic       valid;
    logic       sop;
    logic       eop;
    logic [7:0] data;
  } mfp_byte_s;

  typedef struct packed {
    logic l34_ok;     // IP and TCP checks already passed
    logic is_frag;    // Segment came from an IP fragment
    logic in_order;   // Segment is next in sequence
    logic marker_hit; // Markers place an FPDU start at payload byte 0
  } mfp_meta_s;

  typedef struct packed {
    logic       we;
    logic [7:0] idx;
    mfp_tuple_s tuple;
  } mfp_cfg_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [7:0]  data;
  } mfp_wr_s;

  typedef struct packed {
    logic       valid;
    mfp_err_e   code;
  } mfp_errev_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] conn;
  } mfp_dlv_s;

  typedef struct packed {
    logic        part;   // Split FPDU pending
    logic [1:0]  phase;
    logic [15:0] len;
    logic [15:0] cnt;
    logic [31:0] crc;
    logic [31:0] rx_crc;
    logic [15:0] sidx;   // Local buffer write address
  } mfp_ctx_s;

  // One byte through the reflected CRC32C
  function automatic logic [31:0] mfp_crc_byte(input logic [31:0] crc,
                                               input logic [7:0]  d);
    logic [31:0] c;
    c = crc ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : mfp_crc_byte

endpackage : mfp_pkg

// ### rtl/mfp_rx_place.sv
/*
  FPDU receive framing and placement engine: byte-serial segment input,
  connection lookup, CRC32C check, staged copy to host writes.
  Assumes the segment source holds each byte until o_in_ready, and that
  tuple and meta stay valid from the start-of-segment byte until taken.
*/
// Functional notes
// R1: Check lower layers, then CRC, before placement info
// R2: Classify segment by five-value connection tuple
// R3: In-order split: resume from stored remaining count
// R4: Resume stored partial CRC, finish, then compare
// R5: Place only FPDUs whose CRC check passed
// R6: Copy first portion, then second at computed address; code copies the whole FPDU from the connection buffer once its CRC passes
// R7: Store partial CRC and buffer address, then wait
// R8: Out-of-order non-aligned data held until completable
// R9: Missing segment through CRC before held one
// R10: Decide aligned or lost alignment every segment
// R11: Aligned: payload start is FPDU length header
// R12: Aligned: whole-FPDU CRC, copy from segment directly; code stages every byte and copies from the connection buffer
// R13: Repeat per packed FPDU until segment consumed
// R14: Lost alignment falls back to slower path
// R15: IP fragments leave the fast path
// R16: Deliver only when all covering segments arrived
// R17: Classification completes before any CRC work
// R18: Check value is CRC32C over header and data
// R19: Failed CRC: no placement, error event raised
`timescale 1ns/1ps
module mfp_rx_place #(
  parameter int NUM_CONN   = 4,
  parameter int FPDU_MAX   = mfp_pkg::FPDU_MAX_DEF,
  parameter int HOLD_DEPTH = mfp_pkg::HOLD_DEF
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire mfp_pkg::mfp_byte_s  i_byte,
  input  wire mfp_pkg::mfp_tuple_s i_tuple,
  input  wire mfp_pkg::mfp_meta_s  i_meta,
  input  wire mfp_pkg::mfp_cfg_s   i_cfg,
  output logic                    o_in_ready,
  output mfp_pkg::mfp_wr_s         o_wr,
  output mfp_pkg::mfp_errev_s      o_err,
  output mfp_pkg::mfp_dlv_s        o_deliver
);

  localparam int CW = (NUM_CONN > 1) ? $clog2(NUM_CONN) : 1;

  // ==========================================================================
  // State record
  // ==========================================================================
  typedef struct packed {
    mfp_pkg::mfp_st_e                         st;
    logic [CW-1:0]                            cur;      // Active connection
    logic                                     ooo;      // Out-of-order aligned
    logic                                     repl;     // Source is hold buffer
    logic                                     seg_end;  // Eop already taken
    logic                                     rdy;
    mfp_pkg::mfp_ctx_s                        ctx;      // Working context
    logic [15:0]                              cidx;     // Copy read index
    logic [31:0]                              haddr;    // Host base address
    mfp_pkg::mfp_tuple_s                      tup;      // Captured tuple
    mfp_pkg::mfp_meta_s                       meta;     // Captured meta
    logic [NUM_CONN-1:0]                      vld;
    logic [NUM_CONN-1:0]                      undl;     // Placed, not delivered
    mfp_pkg::mfp_tuple_s [NUM_CONN-1:0]       tup_tbl;
    mfp_pkg::mfp_ctx_s   [NUM_CONN-1:0]       ctx_tbl;
    logic [NUM_CONN-1:0][FPDU_MAX-1:0][7:0]   stage;    // Per-connection buffer
    logic [HOLD_DEPTH-1:0][7:0]               hold;     // One held segment
    logic [15:0]                              hold_len;
    logic [15:0]                              ridx;
    logic                                     hold_pend;
    logic [CW-1:0]                            hold_conn;
    mfp_pkg::mfp_wr_s                         wr;
    mfp_pkg::mfp_errev_s                      err;
    mfp_pkg::mfp_dlv_s                        dlv;
  } mfp_state_s;

  logic [1:0]          rst_sync_r; // Reset release pipeline
  logic                rst_n;      // Synchronised reset
  mfp_state_s          s_r;        // Registered state
  mfp_state_s          s_nxt;      // Next state
  logic [NUM_CONN-1:0] hit;        // Per-entry tuple match
  logic                hit_any;
  logic [CW-1:0]       hit_idx;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  // Assert at once, release after two clean edges
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================================================
  // Connection lookup
  // ==========================================================================
  // Full five-value compare per table entry
  for (genvar g = 0; g < NUM_CONN; g++) begin : g_match
    assign hit[g] = s_r.vld[g] && (s_r.tup_tbl[g] == s_r.tup); // R2
  end

  // Lowest matching entry wins on duplicates
  always_comb begin
    hit_any = 1'b0;
    hit_idx = '0;
    for (int k = NUM_CONN - 1; k >= 0; k--) begin
      if (hit[k]) begin
        hit_any = 1'b1;
        hit_idx = CW'(k);
      end
    end
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin : next_state
    mfp_pkg::mfp_ctx_s c;
    mfp_pkg::mfp_ctx_s fresh;
    logic [7:0]        b;
    logic              bv;
    logic              be;
    logic              done_seg;
    logic              fpdu_next;
    logic              fpdu_done;
    logic              bad;
    logic [16:0]       body;
    c         = s_r.ctx;
    fresh     = '0;
    b         = i_byte.data;
    bv        = i_byte.valid & s_r.rdy;
    be        = i_byte.eop;
    done_seg  = 1'b0;
    fpdu_next = 1'b0;
    fpdu_done = 1'b0;
    bad       = 1'b0;
    body      = '0;
    s_nxt     = s_r;
    s_nxt.wr.valid  = 1'b0;
    s_nxt.err.valid = 1'b0;
    s_nxt.err.code  = mfp_pkg::ERR_NONE;
    s_nxt.dlv.valid = 1'b0;
    // Fresh context: expect a length header at the next byte
    fresh.phase = mfp_pkg::PH_HDR;
    fresh.cnt   = mfp_pkg::HDR_BYTES;
    fresh.crc   = mfp_pkg::CRC_INIT;
    // Replay reads the hold buffer instead of the input port
    if (s_r.repl) begin
      b  = s_r.hold[s_r.ridx];
      bv = 1'b1;
      be = (s_r.ridx == s_r.hold_len - 16'h0001);
    end

    case (s_r.st)
      mfp_pkg::ST_IDLE: begin
        // Capture identity of the new segment
        if (i_byte.valid && i_byte.sop) begin
          s_nxt.tup  = i_tuple;
          s_nxt.meta = i_meta;
          s_nxt.st   = mfp_pkg::ST_CLASS;
        end
      end
      mfp_pkg::ST_CLASS: begin
        s_nxt.cur = hit_idx;
        s_nxt.ooo = 1'b0;
        if (!s_r.meta.l34_ok) begin
          s_nxt.err = '{1'b1, mfp_pkg::ERR_L34};              // R1
          s_nxt.st  = mfp_pkg::ST_DRAIN;
        end else if (s_r.meta.is_frag) begin
          // Fragments go to an upstream reassembly path, not here
          s_nxt.err = '{1'b1, mfp_pkg::ERR_FRAG};             // R15
          s_nxt.st  = mfp_pkg::ST_DRAIN;
        end else if (!hit_any) begin
          s_nxt.err = '{1'b1, mfp_pkg::ERR_NOCONN};
          s_nxt.st  = mfp_pkg::ST_DRAIN;
        end else if (s_r.meta.in_order) begin
          // Split pending means this segment starts mid-FPDU
          c        = s_r.ctx_tbl[hit_idx].part ? s_r.ctx_tbl[hit_idx] : fresh; // R3 R10 R11 R17
          s_nxt.st = mfp_pkg::ST_RUN;
        end else if (s_r.meta.marker_hit) begin
          c         = fresh;                                  // R11
          s_nxt.ooo = 1'b1;
          s_nxt.st  = mfp_pkg::ST_RUN;
        end else if (s_r.hold_pend) begin
          // Only one gap is tracked; a second one is refused
          s_nxt.err = '{1'b1, mfp_pkg::ERR_HOLD};
          s_nxt.st  = mfp_pkg::ST_DRAIN;
        end else begin
          s_nxt.hold_len = '0;                                // R8 R14
          s_nxt.st       = mfp_pkg::ST_HOLD;
        end
      end
      mfp_pkg::ST_RUN: begin
        if (bv) begin
          if (s_r.repl) begin
            s_nxt.ridx = s_r.ridx + 16'h0001;
          end
          // Every FPDU byte lands in the connection buffer
          s_nxt.stage[s_r.cur][c.sidx] = b;
          c.sidx = c.sidx + 16'h0001;
          case (c.phase)
            mfp_pkg::PH_HDR: begin
              c.crc = mfp_pkg::mfp_crc_byte(c.crc, b);        // R18
              if (c.cnt == mfp_pkg::HDR_BYTES) begin
                c.len[15:8] = b;
                c.cnt       = c.cnt - 16'h0001;
              end else begin
                c.len[7:0] = b;                               // R11
                body = ({1'b0, c.len} + {1'b0, mfp_pkg::HDR_BYTES} + mfp_pkg::PAD_MASK)
                       & ~mfp_pkg::PAD_MASK;
                // Oversize or too short: alignment is lost
                bad = (body + {1'b0, mfp_pkg::CRC_BYTES} > 17'(FPDU_MAX)) ||
                      (c.len <= mfp_pkg::PLACE_HDR);          // R10
                c.cnt   = body[15:0] - mfp_pkg::HDR_BYTES;
                c.phase = mfp_pkg::PH_BODY;
              end
            end
            mfp_pkg::PH_BODY: begin
              c.crc = mfp_pkg::mfp_crc_byte(c.crc, b);        // R4 R12
              if (c.cnt == 16'h0001) begin
                c.cnt   = mfp_pkg::CRC_BYTES;
                c.phase = mfp_pkg::PH_CRC;
              end else begin
                c.cnt = c.cnt - 16'h0001;
              end
            end
            default: begin
              c.rx_crc = {c.rx_crc[23:0], b};
              c.cnt    = c.cnt - 16'h0001;
              fpdu_done = (c.cnt == 16'h0000);
            end
          endcase
          if (bad) begin
            // Drop context; held data is dropped too only when it is being replayed
            s_nxt.err = '{1'b1, mfp_pkg::ERR_LEN};
            c = fresh;
            s_nxt.ctx_tbl[s_r.cur] = fresh;
            if (s_r.repl) begin
              s_nxt.repl      = 1'b0;
              s_nxt.hold_pend = 1'b0;
              s_nxt.st        = mfp_pkg::ST_IDLE;
            end else begin
              s_nxt.st = be ? mfp_pkg::ST_IDLE : mfp_pkg::ST_DRAIN;
            end
          end else if (fpdu_done) begin
            s_nxt.seg_end = be;
            s_nxt.st      = mfp_pkg::ST_CHECK;
          end else if (be) begin
            done_seg = 1'b1;
          end
        end
      end
      mfp_pkg::ST_CHECK: begin
        if (c.rx_crc == ~c.crc) begin                         // R4 R12 R18
          s_nxt.haddr = {s_r.stage[s_r.cur][2], s_r.stage[s_r.cur][3],
                         s_r.stage[s_r.cur][4], s_r.stage[s_r.cur][5]}; // R1
          s_nxt.cidx  = mfp_pkg::PLACE_START;
          if (c.len > mfp_pkg::PLACE_HDR) begin
            s_nxt.st = mfp_pkg::ST_COPY;                      // R5
          end else begin
            fpdu_next = 1'b1;
          end
        end else begin
          s_nxt.err = '{1'b1, mfp_pkg::ERR_CRC};              // R19
          fpdu_next = 1'b1;
        end
      end
      mfp_pkg::ST_COPY: begin
        // Split parts sit back to back, so the second part's
        // host address is base plus bytes already placed
        s_nxt.wr.valid = 1'b1;                                // R6 R12
        s_nxt.wr.addr  = s_r.haddr + {16'h0000, s_r.cidx - mfp_pkg::PLACE_START};
        s_nxt.wr.data  = s_r.stage[s_r.cur][s_r.cidx];
        s_nxt.cidx     = s_r.cidx + 16'h0001;
        if (s_r.cidx == c.len + 16'h0001) begin
          s_nxt.undl[s_r.cur] = 1'b1;
          fpdu_next = 1'b1;
        end
      end
      mfp_pkg::ST_HOLD: begin
        if (bv) begin
          if (s_r.hold_len == 16'(HOLD_DEPTH)) begin
            s_nxt.err       = '{1'b1, mfp_pkg::ERR_HOLD};
            s_nxt.hold_pend = 1'b0;
            s_nxt.st        = be ? mfp_pkg::ST_IDLE : mfp_pkg::ST_DRAIN;
          end else begin
            s_nxt.hold[s_r.hold_len] = b;                     // R8
            s_nxt.hold_len = s_r.hold_len + 16'h0001;
            if (be) begin
              s_nxt.hold_pend = 1'b1;
              s_nxt.hold_conn = s_r.cur;
              s_nxt.st        = mfp_pkg::ST_IDLE;
            end
          end
        end
      end
      mfp_pkg::ST_DRAIN: begin
        // Discard the rest of a refused segment
        if (bv && be) begin
          s_nxt.st = mfp_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = mfp_pkg::ST_IDLE;
      end
    endcase

    // Next packed FPDU or end of segment
    if (fpdu_next) begin
      c = fresh;
      if (s_r.seg_end) begin
        done_seg = 1'b1;
      end else begin
        s_nxt.st = mfp_pkg::ST_RUN;                           // R13
      end
    end

    // Segment finished: drop if out of order, replay, or save and deliver
    if (done_seg) begin
      if (s_r.ooo) begin
        // Aligned out-of-order data must end on a boundary
        if (!(c.phase == mfp_pkg::PH_HDR && c.cnt == mfp_pkg::HDR_BYTES)) begin
          s_nxt.err = '{1'b1, mfp_pkg::ERR_ALIGN};
        end
        c = fresh;
        s_nxt.st = mfp_pkg::ST_IDLE;
      end else if (!s_r.repl && s_r.hold_pend && s_r.hold_conn == s_r.cur) begin
        // Gap filled: held bytes follow in the same context
        s_nxt.repl = 1'b1;                                    // R9
        s_nxt.ridx = '0;
        s_nxt.st   = mfp_pkg::ST_RUN;
      end else begin
        if (s_r.repl) begin
          s_nxt.hold_pend = 1'b0;
        end
        s_nxt.repl = 1'b0;
        c.part = !(c.phase == mfp_pkg::PH_HDR && c.cnt == mfp_pkg::HDR_BYTES);
        s_nxt.ctx_tbl[s_r.cur] = c;                           // R7
        if (s_nxt.undl[s_r.cur]) begin
          s_nxt.dlv.valid = 1'b1;                             // R16
          s_nxt.dlv.conn  = 8'(s_r.cur);
          s_nxt.undl[s_r.cur] = 1'b0;
        end
        s_nxt.st = mfp_pkg::ST_IDLE;
      end
    end
    s_nxt.ctx = c;

    // Table install clears any split state for that entry
    if (i_cfg.we) begin
      s_nxt.vld[i_cfg.idx[CW-1:0]]     = 1'b1;
      s_nxt.tup_tbl[i_cfg.idx[CW-1:0]] = i_cfg.tuple;
      s_nxt.ctx_tbl[i_cfg.idx[CW-1:0]] = '0;
    end

    // Ready is registered, so it tracks the state being entered
    s_nxt.rdy = !s_nxt.repl && (s_nxt.st == mfp_pkg::ST_RUN ||
                s_nxt.st == mfp_pkg::ST_HOLD || s_nxt.st == mfp_pkg::ST_DRAIN);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Zero record: idle, empty table, no pending hold
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_in_ready = s_r.rdy;
  assign o_wr       = s_r.wr;
  assign o_err      = s_r.err;
  assign o_deliver  = s_r.dlv;

endmodule : mfp_rx_place
